// >>> hw/tpw_top.sv
// Serial test port with register array and fuse mirror control
`include "tpw_consts.svh"

module tpw_top (
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  input  wire logic       SCLK,
  input  wire logic       DIN,
  output logic            DOUT,
  input  wire logic       TEST_MODE,
  output logic [3:0]      OTP_ADDR,
  input  wire logic [7:0] OTP_RDATA,
  output logic            LOAD_DONE,
  output logic            WRITE_PERMIT
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  tpw_pkg::tpw_core_s  core_reg;
  tpw_pkg::tpw_core_s  core_next;
  logic [7:0]          array_mem [64];

  logic                link_dout;
  logic [5:0]          link_loc;
  logic                link_loc_tgl;
  tpw_pkg::tpw_frame_s link_frame;
  logic                link_frame_tgl;

  logic                ld_we;
  logic [3:0]          ld_addr;
  logic [7:0]          ld_data;
  logic                ld_done;

  logic                test_mode;
  logic                loc_event;
  logic                frame_event;
  logic                ser_we;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic is_mirror(input logic [5:0] loc);
    is_mirror = (loc <= `TPW_LOC_MIRROR_LAST);
  endfunction

  function automatic logic [7:0] status_byte(input logic permit);
    status_byte = '0;
    status_byte[`TPW_PERMIT_BIT] = permit;
  endfunction

  // --------------------------------------------------------------------------
  // Link side
  // --------------------------------------------------------------------------
  // The link clock stops between frames, so its flops are cleared directly
  // from a core flop rather than waiting for link edges that may never come.
  tpw_link u_link (
    .sclk      (SCLK),
    .clr       (core_reg.clr),
    .din       (DIN),
    .rd_byte   (core_reg.rd_byte),
    .dout      (link_dout),
    .loc       (link_loc),
    .loc_tgl   (link_loc_tgl),
    .frame     (link_frame),
    .frame_tgl (link_frame_tgl)
  );

  // --------------------------------------------------------------------------
  // Mirror load
  // --------------------------------------------------------------------------
  tpw_otp_load u_load (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .otp_rdata (OTP_RDATA),
    .otp_addr  (OTP_ADDR),
    .wr_en     (ld_we),
    .wr_addr   (ld_addr),
    .wr_data   (ld_data),
    .done      (ld_done)
  );

  // --------------------------------------------------------------------------
  // Core control
  // --------------------------------------------------------------------------
  // Location and frame words are held by the link for many core cycles after
  // their toggle flips, so they are read directly once the toggle is seen.
  assign test_mode   = core_reg.test_sync[1];
  assign loc_event   = core_reg.loc_sync[2] ^ core_reg.loc_sync[1];
  assign frame_event = core_reg.frame_sync[2] ^ core_reg.frame_sync[1];

  always_comb begin
    ser_we = 1'b0;
    if (frame_event && link_frame.dir && ld_done) begin
      if (link_frame.loc == `TPW_LOC_MIRROR_CMD ||
          link_frame.loc == `TPW_LOC_PROG_STATUS) begin
        ser_we = 1'b0;
      end else if (is_mirror(link_frame.loc)) begin
        ser_we = test_mode && core_reg.permit;
      end else begin
        ser_we = 1'b1;
      end
    end
  end

  always_comb begin
    core_next            = core_reg;
    core_next.clr        = 1'b0;
    core_next.test_sync  = {core_reg.test_sync[0], TEST_MODE};
    core_next.loc_sync   = {core_reg.loc_sync[1:0], link_loc_tgl};
    core_next.frame_sync = {core_reg.frame_sync[1:0], link_frame_tgl};
    if (loc_event) begin
      if (link_loc == `TPW_LOC_PROG_STATUS) begin
        core_next.rd_byte = status_byte(core_reg.permit);
      end else if (link_loc == `TPW_LOC_MIRROR_CMD) begin
        core_next.rd_byte = 8'h00;
      end else begin
        core_next.rd_byte = array_mem[link_loc];
      end
    end
    if (frame_event && link_frame.dir &&
        link_frame.loc == `TPW_LOC_MIRROR_CMD &&
        link_frame.data == `TPW_PERMIT_CMD_VAL) begin
      core_next.permit = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      core_reg <= '{clr: 1'b1, test_sync: 2'h0, loc_sync: 3'h0,
                    frame_sync: 3'h0, rd_byte: 8'h00,
                    permit: `TPW_PERMIT_RESET};
    end else begin
      core_reg <= core_next;
    end
  end

  // Array is not reset; mirrors are refilled by the load, others are scratch
  always_ff @(posedge CORE_CLK) begin
    if (ld_we) begin
      array_mem[{2'h0, ld_addr}] <= ld_data;
    end else if (ser_we) begin
      array_mem[link_frame.loc] <= link_frame.data;
    end
  end

  assign DOUT         = link_dout;
  assign LOAD_DONE    = ld_done;
  assign WRITE_PERMIT = core_reg.permit;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  chk_permit_set: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (frame_event && link_frame.dir && link_frame.loc == 6'h20 &&
     link_frame.data == 8'h00) |=> WRITE_PERMIT [*3])
    else $error("permit flag not set by zero write to command location");

  chk_mirror_guard: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (ser_we && link_frame.loc <= 6'h0f) |-> (test_mode && core_reg.permit))
    else $error("mirror written without test mode and permit");

  chk_write_dir: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ser_we |-> (frame_event && link_frame.dir) ##1 (array_mem[$past(link_frame.loc)]
      == $past(link_frame.data)))
    else $error("array write without direction bit or with wrong data");

  chk_status_read: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (loc_event && link_loc == 6'h29) |=> (core_reg.rd_byte == {2'h0, WRITE_PERMIT, 5'h00}))
    else $error("status location does not show permit flag");

endmodule // tpw_top

// >>> hw/tpw_consts.svh
// Constants of the serial test port and mirror load block
//
// Summary of operation
// - Each register access is exactly one sixteen-bit serial frame from the master.
// - Write data is taken on rising edges nine to sixteen into the location.
// - Prior location contents leave on the output over falling edges eight to fifteen.
// - Mirror registers load from fuse storage within sixteen clocks after reset release.
// - Serial writes may overwrite mirror registers only in test mode.
// - Mirror writes are blocked unless the permit flag, location 0x29 bit 5, is set.
// - Writing value zero to location 0x20 sets the mirror write permit flag.
// - Frame holds six location bits, then direction, then a spare bit, then eight data bits in low byte.
// - Clock idles low; input sampled on rising edges, output changes on falling edges.
// - Direction one is a write, direction zero a read of the location.
`ifndef TPW_CONSTS_SVH
`define TPW_CONSTS_SVH

// --------------------------------------------------------------------------
// Locations and fields
// --------------------------------------------------------------------------
`define TPW_LOC_MIRROR_CMD  6'h20
`define TPW_LOC_PROG_STATUS 6'h29
`define TPW_LOC_MIRROR_LAST 6'h0f
`define TPW_PERMIT_BIT      5
`define TPW_PERMIT_CMD_VAL  8'h00
`define TPW_PERMIT_RESET    1'b0

// --------------------------------------------------------------------------
// Frame timing, in rising-edge counts, and last fuse index of the load
// --------------------------------------------------------------------------
`define TPW_EDGE_LOC_LAST   4'h5
`define TPW_EDGE_FRAME_LAST 4'hf
`define TPW_EDGE_DOUT_FIRST 4'h8
`define TPW_OTP_LAST_IDX    4'hf

`endif

// >>> hw/tpw_pkg.sv
// Types shared by the serial test port and mirror load block
package tpw_pkg;

  typedef struct packed {
    logic [5:0] loc;
    logic       dir;
    logic       spare;
    logic [7:0] data;
  } tpw_frame_s;

  typedef struct packed {
    logic [3:0]  edges;
    logic [14:0] shift;
    logic [5:0]  loc;
    logic        loc_tgl;
    tpw_frame_s  frame;
    logic        frame_tgl;
  } tpw_link_s;

  typedef struct packed {
    logic [3:0] idx;
    logic       busy;
    logic       done;
  } tpw_load_s;

  typedef struct packed {
    logic       clr;
    logic [1:0] test_sync;
    logic [2:0] loc_sync;
    logic [2:0] frame_sync;
    logic [7:0] rd_byte;
    logic       permit;
  } tpw_core_s;

endpackage : tpw_pkg

// >>> hw/tpw_link.sv
// Serial shifter running on the master's clock
`include "tpw_consts.svh"

module tpw_link (
  input  wire logic               sclk,
  input  wire logic               clr,
  input  wire logic               din,
  input  wire logic [7:0]         rd_byte,
  output logic                    dout,
  output logic [5:0]              loc,
  output logic                    loc_tgl,
  output tpw_pkg::tpw_frame_s     frame,
  output logic                    frame_tgl
);

  tpw_pkg::tpw_link_s link_reg;
  tpw_pkg::tpw_link_s link_next;
  logic               dout_reg;

  // --------------------------------------------------------------------------
  // Rising-edge side
  // --------------------------------------------------------------------------
  always_comb begin
    link_next       = link_reg;
    link_next.edges = link_reg.edges + 4'h1;
    link_next.shift = {link_reg.shift[13:0], din};
    if (link_reg.edges == `TPW_EDGE_LOC_LAST) begin
      link_next.loc     = {link_reg.shift[4:0], din};
      link_next.loc_tgl = ~link_reg.loc_tgl;
    end
    if (link_reg.edges == `TPW_EDGE_FRAME_LAST) begin
      link_next.frame     = {link_reg.shift, din};
      link_next.frame_tgl = ~link_reg.frame_tgl;
    end
  end

  // No select line, so a lost edge shifts every later frame until reset
  always_ff @(posedge sclk or posedge clr) begin
    if (clr) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // --------------------------------------------------------------------------
  // Falling-edge side
  // --------------------------------------------------------------------------
  always_ff @(negedge sclk or posedge clr) begin
    if (clr) begin
      dout_reg <= 1'b0;
    end else if (link_reg.edges >= `TPW_EDGE_DOUT_FIRST) begin
      dout_reg <= rd_byte[3'(4'hf - link_reg.edges)];
    end else begin
      dout_reg <= 1'b0;
    end
  end

  assign dout      = dout_reg;
  assign loc       = link_reg.loc;
  assign loc_tgl   = link_reg.loc_tgl;
  assign frame     = link_reg.frame;
  assign frame_tgl = link_reg.frame_tgl;

  chk_edge_wrap: assert property (@(posedge sclk) disable iff (clr)
    (link_reg.edges == 4'hf) |=> (link_reg.edges == 4'h0))
    else $error("edge counter did not wrap at sixteen");

  chk_loc_grab: assert property (@(posedge sclk) disable iff (clr)
    (link_reg.edges == 4'h5) |=> ($changed(loc_tgl) && $stable(frame_tgl)))
    else $error("location not handed over after sixth edge");

  chk_frame_grab: assert property (@(posedge sclk) disable iff (clr)
    (link_reg.edges == 4'hf) |=> ($changed(frame_tgl) && frame.data[0] == $past(din)))
    else $error("frame not handed over after sixteenth edge");

  chk_dout_quiet: assert property (@(posedge sclk) disable iff (clr)
    (link_reg.edges < 4'h8 && link_reg.edges != 4'h0) |-> !dout)
    else $error("serial output active outside data phase");

  chk_dout_bit: assert property (@(posedge sclk) disable iff (clr)
    (link_reg.edges >= 4'h8) |-> (dout == rd_byte[3'(4'hf - link_reg.edges)]))
    else $error("serial output bit does not match prior contents");

endmodule // tpw_link

// >>> hw/tpw_otp_load.sv
// Copies the fuse contents into the mirror locations after reset
`include "tpw_consts.svh"

module tpw_otp_load (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] otp_rdata,
  output logic [3:0]      otp_addr,
  output logic            wr_en,
  output logic [3:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            done
);

  tpw_pkg::tpw_load_s load_reg;
  tpw_pkg::tpw_load_s load_next;

  always_comb begin
    load_next = load_reg;
    if (load_reg.busy) begin
      load_next.idx = load_reg.idx + 4'h1;
      if (load_reg.idx == `TPW_OTP_LAST_IDX) begin
        load_next.busy = 1'b0;
        load_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      load_reg <= '{idx: 4'h0, busy: 1'b1, done: 1'b0};
    end else begin
      load_reg <= load_next;
    end
  end

  // Fuse read is combinational, so data for idx is valid in the same cycle
  assign otp_addr = load_reg.idx;
  assign wr_en    = load_reg.busy;
  assign wr_addr  = load_reg.idx;
  assign wr_data  = otp_rdata;
  assign done     = load_reg.done;

  // Sixteen writes land on the first sixteen edges; done is seen from the next
  chk_load_span: assert property (@(posedge clk)
    (rst ##1 !rst) |-> (!done [*8] ##1 !done [*7] ##1 !done ##1 done))
    else $error("mirror load not finished in sixteen cycles");

  chk_load_step: assert property (@(posedge clk) disable iff (rst)
    wr_en |=> (otp_addr == $past(otp_addr) + 4'h1) && (done == ($past(otp_addr) == 4'hf)))
    else $error("mirror load index out of step");

endmodule // tpw_otp_load

// >>> tb/tpw_master.sv
// Model of the serial test master that drives frames into the port
module tpw_master (
  output logic      SCLK,
  output logic      DIN,
  input  wire logic DOUT
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    SCLK = 1'b0;
    DIN  = 1'b0;
  end

  // ------------------------------------------------------------------
  // One frame
  // ------------------------------------------------------------------
  // Clock stands low between frames; only whole frames are ever sent
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    for (int i = 15; i >= 0; i--) begin
      DIN = f[i];
      #80 SCLK = 1'b1;
      if (i < 8) begin
        rd[i] = DOUT;
      end
      #80 SCLK = 1'b0;
    end
    // Released line must not look like the last data bit
    DIN = ~DIN;
  endtask
endmodule // tpw_master

// >>> tb/tpw_top_tb.sv
// Self-checking bench for the serial test port and mirror load block
module tpw_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic       CORE_CLK = 1'b0;
  logic       RESET = 1'b1;
  logic       TEST_MODE = 1'b0;
  logic       SCLK;
  logic       DIN;
  logic       DOUT;
  logic [3:0] OTP_ADDR;
  logic [7:0] OTP_RDATA;
  logic       LOAD_DONE;
  logic       WRITE_PERMIT;
  int         err_count = 0;
  int         tests_run = 0;

  // Fuse contents differ per index so a wrong pairing shows
  function automatic logic [7:0] otp(input logic [3:0] a);
    return {a, ~a} ^ 8'h96;
  endfunction

  assign OTP_RDATA = otp(OTP_ADDR);
  always #10 CORE_CLK = ~CORE_CLK;

  tpw_top i_tpw_top (
    .CORE_CLK    (CORE_CLK),
    .RESET       (RESET),
    .SCLK        (SCLK),
    .DIN         (DIN),
    .DOUT        (DOUT),
    .TEST_MODE   (TEST_MODE),
    .OTP_ADDR    (OTP_ADDR),
    .OTP_RDATA   (OTP_RDATA),
    .LOAD_DONE   (LOAD_DONE),
    .WRITE_PERMIT(WRITE_PERMIT)
  );

  tpw_master i_tpw_master (
    .SCLK(SCLK),
    .DIN (DIN),
    .DOUT(DOUT)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic summarize;
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic xf(input logic [5:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] old);
    i_tpw_master.xfer({a, w, 1'b0, d}, old);
    #40;
    chk1("dout_idle", 1'b0, DOUT);
    repeat (8) @(posedge CORE_CLK);
  endtask

  task automatic do_reset(output int n);
    @(posedge CORE_CLK) #1 RESET = 1'b1;
    repeat (4) @(posedge CORE_CLK);
    #1 RESET = 1'b0;
    n = 0;
    while (LOAD_DONE !== 1'b1 && n < 40) begin
      @(posedge CORE_CLK);
      #1 n++;
    end
  endtask

  task automatic set_test(input logic t);
    @(posedge CORE_CLK) #1 TEST_MODE = t;
    repeat (4) @(posedge CORE_CLK);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_load;
    int         n;
    logic [7:0] v;
    do_reset(n);
    chk1("load_in_16", 1'b1, n <= 16);
    chk1("permit_rst", 1'b0, WRITE_PERMIT);
    for (int i = 0; i < 16; i++) begin
      xf(i[5:0], 1'b0, 8'h00, v);
      chk8("mirror_load", otp(i[3:0]), v);
    end
    $display("test load ended");
  endtask

  task automatic t_block;
    logic [7:0] v;
    set_test(1'b1);
    xf(6'h03, 1'b1, 8'ha5, v);
    chk8("old_on_wr", otp(4'h3), v);
    xf(6'h03, 1'b0, 8'h00, v);
    chk8("blocked_wr", otp(4'h3), v);
    xf(6'h20, 1'b1, 8'h55, v);
    chk1("permit_other", 1'b0, WRITE_PERMIT);
    $display("test block ended");
  endtask

  task automatic t_permit;
    logic [7:0] v;
    xf(6'h20, 1'b1, 8'h00, v);
    chk1("permit_set", 1'b1, WRITE_PERMIT);
    xf(6'h29, 1'b0, 8'h00, v);
    chk8("status_read", 8'h20, v);
    $display("test permit ended");
  endtask

  task automatic t_mirror;
    logic [7:0] v;
    xf(6'h0f, 1'b1, 8'h5a, v);
    chk8("mir_old", otp(4'hf), v);
    xf(6'h0f, 1'b1, 8'ha5, v);
    chk8("mir_wr", 8'h5a, v);
    set_test(1'b0);
    xf(6'h0e, 1'b1, 8'h11, v);
    xf(6'h0e, 1'b0, 8'h00, v);
    chk8("no_test_wr", otp(4'he), v);
    $display("test mirror ended");
  endtask

  task automatic t_plain;
    logic [7:0] v;
    xf(6'h3f, 1'b1, 8'hc3, v);
    xf(6'h3f, 1'b0, 8'hff, v);
    chk8("plain_wr", 8'hc3, v);
    xf(6'h3f, 1'b0, 8'h00, v);
    chk8("read_no_wr", 8'hc3, v);
    $display("test plain ended");
  endtask

  task automatic t_resync;
    int         n;
    logic [7:0] v;
    do_reset(n);
    chk1("permit_clr", 1'b0, WRITE_PERMIT);
    xf(6'h0f, 1'b0, 8'h00, v);
    chk8("reload", otp(4'hf), v);
    $display("test resync ended");
  endtask

  initial begin
    t_load;
    t_block;
    t_permit;
    t_mirror;
    t_plain;
    t_resync;
    summarize;
  end

  // About 29 frames of 2.8 us each; generous margin
  initial begin
    #300000;
    err_count++;
    summarize;
  end
endmodule // tpw_top_tb
